// ===== design/cfg_apb_port.sv
`timescale 1ns/1ps
`include "cfg_port_params.svh"
// Operation
// - each access completes after variable delay
// - unmapped address times out with slave error
// - address bit 23 selects shadow access
// - wide table owns a full-width shadow
// - direct read also loads the shadow
// - shadow reads return the captured snapshot
// - only direct table reads and writes wait memory
// - shadow writes load; direct write commits
// - commit overwrites intervening core updates
// - wide entries step address by power two
// - lowest address holds least significant bits
module cfg_apb_port import cfg_port_pkg::*; (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [23:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic coreBusy,
	input wire logic coreWrEn,
	input wire logic [1:0] coreWrIdx,
	input wire logic [64:0] coreWrData,
	input wire logic [1:0] coreRdIdx,
	output logic [64:0] coreRdData,
	output logic [31:0] cfgCtrl
);
	localparam int NAR_RESP = 5;
	localparam int ACC_RESP = 4;
	localparam int MEM_RESP = 10;
	localparam int TMO_RESP = 65;

	logic rstMeta, rstSyncN;
	portState_t state_r;
	target_t tgt, tgt_r;
	logic [22:0] wordAddr;
	logic shadowSel, startAcc;
	logic wr_r, err_r;
	logic [6:0] toCnt_r;
	logic [5:0] narCnt_r;
	logic narDone, tabDone, tmo;
	logic [31:0] tabRd;
	// done strobe from the table, one cycle wide
	logic tabRd_v;
	logic [31:0] errCount_r;

	// ****************************************
	// reset release
	// ****************************************
	// release is synchronous so no flop sees a half-cycle reset edge
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			rstMeta <= 1'b0;
			rstSyncN <= 1'b0;
		end else begin
			rstMeta <= 1'b1;
			rstSyncN <= rstMeta;
		end
	end

	// ****************************************
	// address decode
	// ****************************************
	// bit 23 is a flag, not address
	assign wordAddr = paddr[22:0];
	assign shadowSel = paddr[`SHADOW_BIT];
	assign startAcc = state_r == ST_IDLE && psel && penable;

	// no range check, unused words fall through
	always_comb begin
		tgt = T_NONE;
		if (wordAddr == `CTRL_ADDR) begin
			tgt = T_CTRL;
		end else if (wordAddr == `STAT_ADDR) begin
			tgt = T_STAT;
		end else if (wordAddr[22:4] == `TAB_PAGE &&
			wordAddr[1:0] != `TAB_WORDS) begin
			tgt = T_TAB;
		end
	end

	// ****************************************
	// access sequencing
	// ****************************************
	assign narDone = state_r == ST_BUSY && narCnt_r == 6'h01 &&
		(tgt_r == T_CTRL || tgt_r == T_STAT);
	assign tabDone = state_r == ST_BUSY && tgt_r == T_TAB && tabRd_v;
	// fixed count beyond the slowest mapped path
	assign tmo = state_r == ST_BUSY && toCnt_r == `TIMEOUT_CYC - 7'h01;

	// access phase held until an answer
	always_ff @(posedge mclk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			state_r <= ST_IDLE;
		end else begin
			case (state_r)
				ST_IDLE: if (startAcc) state_r <= ST_BUSY;
				ST_BUSY: if (narDone || tabDone || tmo) state_r <= ST_RESP;
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			tgt_r <= T_NONE;
			wr_r <= 1'b0;
			toCnt_r <= 7'h00;
			narCnt_r <= 6'h00;
		end else if (startAcc) begin
			tgt_r <= tgt;
			wr_r <= pwrite;
			toCnt_r <= 7'h00;
			narCnt_r <= cycLat(`NARROW_LAT, coreBusy);
		end else if (state_r == ST_BUSY) begin
			toCnt_r <= toCnt_r + 7'h01;
			narCnt_r <= narCnt_r - 6'h01;
		end
	end

	// ****************************************
	// narrow registers and answer
	// ****************************************
	// error count is visible on the status word
	always_ff @(posedge mclk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			cfgCtrl <= `CTRL_RST;
			errCount_r <= 32'h0;
		end else begin
			if (narDone && wr_r && tgt_r == T_CTRL) begin
				cfgCtrl <= pwdata;
			end
			if (tmo) begin
				errCount_r <= errCount_r + 32'h1;
			end
		end
	end

	// answer data captured once, writes read back zero
	always_ff @(posedge mclk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			prdata <= 32'h0;
			err_r <= 1'b0;
		end else if (state_r == ST_BUSY) begin
			err_r <= tmo;
			if (wr_r || tmo) begin
				prdata <= 32'h0;
			end else if (tabDone) begin
				prdata <= tabRd;
			end else if (narDone) begin
				prdata <= tgt_r == T_CTRL ? cfgCtrl : errCount_r;
			end
		end
	end

	assign pready = state_r == ST_RESP;
	assign pslverr = pready && err_r;

	wide_table_bank i_wide_table_bank (
		.clk(mclk),
		.rstN(rstSyncN),
		.req(startAcc && tgt == T_TAB),
		.reqWrite(pwrite),
		.reqShadow(shadowSel),
		.reqIdx(wordAddr[3:2]),
		.reqWord(wordAddr[1:0]),
		.reqWdata(pwdata),
		.loadHigh(coreBusy),
		.done(tabRd_v),
		.rdData(tabRd),
		.coreWrEn(coreWrEn),
		.coreWrIdx(coreWrIdx),
		.coreWrData(coreWrData),
		.coreRdIdx(coreRdIdx),
		.coreRdData(coreRdData)
	);

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstSyncN);

	a_timeout_err: assert property (startAcc && tgt == T_NONE
		|-> ##[TMO_RESP:TMO_RESP] (pready && pslverr))
		else $error("unmapped access did not time out");
	a_mapped_ok: assert property (pready && tgt_r != T_NONE
		|-> !pslverr)
		else $error("mapped access flagged an error");
	a_wait_held: assert property (startAcc |=> !pready [*3])
		else $error("access completed too early");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	a_shadow_fast: assert property (startAcc && tgt == T_TAB && shadowSel
		|-> ##[ACC_RESP:ACC_RESP] pready)
		else $error("shadow access waited for memory");
	a_mem_wait: assert property (startAcc && tgt == T_TAB && !shadowSel
		&& !coreBusy |-> ##[MEM_RESP:MEM_RESP] pready)
		else $error("direct table access delay wrong");
	a_narrow_lat: assert property (startAcc && tgt != T_NONE
		&& tgt != T_TAB && !coreBusy |-> ##[NAR_RESP:NAR_RESP] pready)
		else $error("register access delay wrong");
	a_ctrl_commit: assert property (pready && wr_r && tgt_r == T_CTRL
		|-> cfgCtrl == pwdata)
		else $error("control word not written");

	c_shadow_read: cover property (startAcc && tgt == T_TAB && shadowSel
		&& !pwrite);
	c_direct_commit: cover property (startAcc && tgt == T_TAB && !shadowSel
		&& pwrite);
	c_timeout: cover property (pready && pslverr);
	c_loaded: cover property (startAcc && coreBusy);
endmodule // cfg_apb_port

// ===== design/cfg_port_params.svh
`ifndef CFG_PORT_PARAMS_SVH
`define CFG_PORT_PARAMS_SVH
// ****************************************
// bus geometry
// ****************************************
`define ADDR_W 24
`define DATA_W 32
`define SHADOW_BIT 23
// ****************************************
// word offsets of the mapped locations
// ****************************************
`define CTRL_ADDR 23'h000000
`define STAT_ADDR 23'h000001
// table occupies words 0x10..0x1F, four-word stride, three mapped words per entry
`define TAB_PAGE 19'h00001
`define TAB_WORDS 2'h3
`define TAB_WIDTH 65
`define CTRL_RST 32'h00000000
// ****************************************
// response timing in core clock cycles
// ****************************************
`define NARROW_LAT 6'h04
`define MEM_LAT 6'h08
`define ACC_LAT 6'h02
`define LOAD_EXTRA 6'h10
`define TIMEOUT_CYC 7'h40
`endif

// ===== design/cfg_port_pkg.sv
package cfg_port_pkg;
	`include "cfg_port_params.svh"

	typedef enum logic [1:0] {ST_IDLE, ST_BUSY, ST_RESP} portState_t;
	typedef enum logic [1:0] {T_NONE, T_CTRL, T_STAT, T_TAB} target_t;

	// response delay, stretched while the core is loaded
	function automatic logic [5:0] cycLat(logic [5:0] base, logic busy);
		return busy ? base + `LOAD_EXTRA : base;
	endfunction

	// little-endian word pick out of a wide value
	function automatic logic [31:0] wordOf(logic [95:0] v, logic [1:0] w);
		logic [95:0] s;
		s = v >> {w, 5'h00};
		return s[31:0];
	endfunction

	// replace one word of a wide value
	function automatic logic [95:0] putWord(logic [95:0] v, logic [1:0] w,
		logic [31:0] d);
		logic [95:0] m;
		m = {64'h0, 32'hFFFFFFFF} << {w, 5'h00};
		return (v & ~m) | ({64'h0, d} << {w, 5'h00});
	endfunction
endpackage

// ===== design/wide_table_bank.sv
`timescale 1ns/1ps
`include "cfg_port_params.svh"
module wide_table_bank import cfg_port_pkg::*; (
	input wire logic clk,
	input wire logic rstN,
	input wire logic req,
	input wire logic reqWrite,
	input wire logic reqShadow,
	input wire logic [1:0] reqIdx,
	input wire logic [1:0] reqWord,
	input wire logic [31:0] reqWdata,
	input wire logic loadHigh,
	output logic done,
	output logic [31:0] rdData,
	input wire logic coreWrEn,
	input wire logic [1:0] coreWrIdx,
	input wire logic [64:0] coreWrData,
	input wire logic [1:0] coreRdIdx,
	output logic [64:0] coreRdData
);
	logic [95:0] acc_r;
	logic [64:0] ent_r [0:3];
	logic busy_r;
	logic [5:0] cnt_r;
	logic opWr_r, opSh_r;
	logic [1:0] opIdx_r, opWord_r;
	logic [31:0] opData_r;
	logic fire;
	logic [95:0] commitVal;

	assign fire = busy_r && cnt_r == 6'h01;
	// own word from the bus, the rest from the shadow
	assign commitVal = putWord(acc_r, opWord_r, opData_r);

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			busy_r <= 1'b0;
			cnt_r <= 6'h00;
			opWr_r <= 1'b0;
			opSh_r <= 1'b0;
			opIdx_r <= 2'h0;
			opWord_r <= 2'h0;
			opData_r <= 32'h0;
		end else if (req) begin
			busy_r <= 1'b1;
			// shadow hits never wait for the memory
			cnt_r <= reqShadow ? `ACC_LAT : cycLat(`MEM_LAT, loadHigh);
			opWr_r <= reqWrite;
			opSh_r <= reqShadow;
			opIdx_r <= reqIdx;
			opWord_r <= reqWord;
			opData_r <= reqWdata;
		end else if (fire) begin
			busy_r <= 1'b0;
		end else if (busy_r) begin
			cnt_r <= cnt_r - 6'h01;
		end
	end

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			acc_r <= 96'h0;
		end else if (fire && !opWr_r && !opSh_r) begin
			acc_r <= {31'h0, ent_r[opIdx_r]};
		end else if (fire && opWr_r && opSh_r) begin
			acc_r <= putWord(acc_r, opWord_r, opData_r);
		end
	end

	// commit overrides a same-cycle core update
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			for (int i = 0; i < 4; i++) begin
				ent_r[i] <= 65'h0;
			end
		end else begin
			if (coreWrEn) begin
				ent_r[coreWrIdx] <= coreWrData;
			end
			if (fire && opWr_r && !opSh_r) begin
				ent_r[opIdx_r] <= commitVal[64:0];
			end
		end
	end

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			rdData <= 32'h0;
			done <= 1'b0;
			coreRdData <= 65'h0;
		end else begin
			done <= fire;
			coreRdData <= ent_r[coreRdIdx];
			if (fire && !opWr_r) begin
				rdData <= opSh_r ? wordOf(acc_r, opWord_r) :
					wordOf({31'h0, ent_r[opIdx_r]}, opWord_r);
			end
		end
	end

	// ****************************************
	// checks
	// ****************************************
	a_direct_snap: assert property (@(posedge clk) disable iff (!rstN)
		done && !opWr_r && !opSh_r && !$past(coreWrEn)
		|-> acc_r == {31'h0, ent_r[opIdx_r]})
		else $error("shadow not loaded by direct read");
	a_shadow_only: assert property (@(posedge clk) disable iff (!rstN)
		done && opWr_r && opSh_r && !$past(coreWrEn)
		|-> $stable(ent_r[opIdx_r]))
		else $error("shadow write changed the entry");
	a_commit_word: assert property (@(posedge clk) disable iff (!rstN)
		done && opWr_r && !opSh_r && opWord_r != 2'h2
		|-> wordOf({31'h0, ent_r[opIdx_r]}, opWord_r) == opData_r)
		else $error("direct write lost its own word");
endmodule // wide_table_bank

// ===== dv/apb_config_wide_access_tb_top.sv
`timescale 1ns/1ps
module apb_config_wide_access_tb_top;
	typedef struct {logic [31:0] d; logic e; int n;} note_t;
	logic mclk = 0, rstn = 0, go = 0, wr = 0, pready, pslverr, busy;
	logic psel, penable, pwrite, coreBusy = 0, coreWrEn = 0;
	logic [23:0] addr = 0, paddr, b, s;
	logic [31:0] wd = 0, pwdata, prdata, cfgCtrl, v;
	logic [1:0] coreWrIdx = 0, coreRdIdx = 0;
	logic [64:0] coreWrData = 0, coreRdData, e, n;
	logic [23:0] bad [4] = '{24'h000002, 24'h00000F, 24'h000020, 24'h7FFFFF};
	note_t expQ [$];
	note_t nt;
	int fails = 0, checksDone = 0, cyc = 0, i, toCnt = 0;
	always #5 mclk = ~mclk;
	cfg_apb_port i_cfg_apb_port (.mclk(mclk), .rstn(rstn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.coreBusy(coreBusy), .coreWrEn(coreWrEn), .coreWrIdx(coreWrIdx),
		.coreWrData(coreWrData), .coreRdIdx(coreRdIdx),
		.coreRdData(coreRdData), .cfgCtrl(cfgCtrl));
	apb_req_model i_apb_req_model (.mclk(mclk), .rstn(rstn), .go(go),
		.wr(wr), .addr(addr), .wd(wd), .pready(pready), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.busy(busy));
	// ****************************************
	// shared tasks
	// ****************************************
	task automatic results();
		$display("checks %0d fails %0d", checksDone, fails);
		if (fails == 0 && checksDone > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(string nm, logic [95:0] ex, logic [95:0] got);
		checksDone++;
		if (got !== ex) begin
			fails++;
			$display("CHECK FAILED %s exp %h got %h", nm, ex, got);
		end
	endtask
	// note the answer, then hand one access to the requester
	task automatic acc(logic w, logic [23:0] a, logic [31:0] d,
		logic [31:0] ex, logic er, int lat);
		int k;
		expQ.push_back('{ex, er, lat});
		go = 1'b1;
		wr = w;
		addr = a;
		wd = d;
		@(posedge mclk) #1;
		go = 1'b0;
		for (k = 0; k < 200 && busy !== 1'b0; k++) @(posedge mclk) #1;
		if (k == 200) begin
			fails++;
			results();
		end
	endtask
	task automatic cw(logic [1:0] idx, logic [64:0] d);
		coreWrEn = 1'b1;
		coreWrIdx = idx;
		coreWrData = d;
		@(posedge mclk) #1;
		coreWrEn = 1'b0;
	endtask
	task automatic cr(logic [1:0] idx, logic [64:0] ex);
		coreRdIdx = idx;
		@(posedge mclk) #1;
		chk("coreRdData", ex, coreRdData);
	endtask
	// ****************************************
	// response watcher
	// ****************************************
	// answers are judged at negedge, once pready has settled
	always @(negedge mclk) begin
		if (psel && penable) cyc++;
		if (pready === 1'b1) begin
			if (expQ.size() == 0) begin
				chk("spurious pready", 0, 1);
			end else begin
				nt = expQ.pop_front();
				chk("prdata", nt.d, prdata);
				chk("pslverr", nt.e, pslverr);
				chk("latency", nt.n + 1, cyc);
			end
			cyc = 0;
		end
	end
	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		void'($urandom(81));
		repeat (5) @(posedge mclk);
		#1 rstn = 1'b1;
		repeat (4) @(posedge mclk) #1;
		chk("cfgCtrl reset", 0, cfgCtrl);
		v = $urandom;
		acc(1, 24'h000000, v, 0, 0, 5);
		chk("cfgCtrl", v, cfgCtrl);
		coreBusy = 1'b1;
		acc(0, 24'h000000, 0, v, 0, 21);
		coreBusy = 1'b0;
		for (i = 0; i < 4; i++) begin
			acc(i[0], bad[i], 0, 0, 1, 65);
			toCnt++;
		end
		for (i = 0; i < 4; i++) begin
			b = 24'h000010 + 24'(4 * i);
			s = b | 24'h800000;
			e = 65'({$urandom, $urandom, $urandom});
			n = 65'({$urandom, $urandom, $urandom});
			v = $urandom;
			cw(i[1:0], e);
			acc(0, b, 0, e[31:0], 0, 10);
			// core update after the snapshot must stay unseen
			cw(i[1:0], ~e);
			acc(0, s + 24'h1, 0, e[63:32], 0, 4);
			acc(0, s + 24'h2, 0, {31'h0, e[64]}, 0, 4);
			acc(1, s, n[31:0], 0, 0, 4);
			acc(1, s + 24'h1, n[63:32], 0, 0, 4);
			cw(i[1:0], e);
			acc(1, b + 24'h2, {v[31:1], n[64]}, 0, 0, 10);
			cr(i[1:0], n);
			acc(0, b, 0, n[31:0], 0, 10);
			acc(1, b + 24'h1, v, 0, 0, 10);
			cr(i[1:0], {n[64], v, n[31:0]});
			acc(0, b + 24'h3, 0, 0, 1, 65);
			toCnt++;
		end
		coreBusy = 1'b1;
		acc(0, 24'h00001C, 0, n[31:0], 0, 26);
		// shadow hit under load still skips the memory wait
		acc(0, 24'h80001D, 0, v, 0, 4);
		coreBusy = 1'b0;
		acc(1, 24'h000001, 32'hFFFFFFFF, 0, 0, 5);
		acc(0, 24'h000001, 0, 32'(toCnt), 0, 5);
		repeat (3) @(posedge mclk);
		chk("queue empty", 0, expQ.size());
		results();
	end
endmodule // apb_config_wide_access_tb_top

// ===== dv/apb_req_model.sv
`timescale 1ns/1ps
// ****************************************
// requester standing in for the cpu side
// ****************************************
module apb_req_model (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic go,
	input wire logic wr,
	input wire logic [23:0] addr,
	input wire logic [31:0] wd,
	input wire logic pready,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [23:0] paddr,
	output logic [31:0] pwdata,
	output logic busy
);
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			psel <= 1'b0;
			penable <= 1'b0;
			pwrite <= 1'b0;
			paddr <= 24'h000000;
			pwdata <= 32'h00000000;
		end else if (psel && penable && pready) begin
			// released lines flip so stale values never look valid
			psel <= 1'b0;
			penable <= 1'b0;
			pwrite <= ~pwrite;
			paddr <= ~paddr;
			pwdata <= ~pwdata;
		end else if (psel) begin
			penable <= 1'b1;
		end else if (go) begin
			psel <= 1'b1;
			pwrite <= wr;
			paddr <= addr;
			pwdata <= wd;
		end
	end
	assign busy = psel;
endmodule // apb_req_model
